// [design/clamp_timing_regs.sv]
// Clamp timing and clock supervision register bank with its clamp mode decode.
// Assumes the frame decoder presents one-cycle read and write strobes with an address.
`timescale 1ns/1ps
module clamp_timing_regs (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [clamp_regs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clamp_regs_pkg::DATA_W-1:0] wdata_in,
  input wire logic frame_done_in,
  input wire logic frame_bad_in,
  input wire logic tally_valid_in,
  input wire logic [7:0] tally_in,
  output logic [clamp_regs_pkg::DATA_W-1:0] rdata_out,
  output logic rdata_valid_out,
  output logic [7:0] clamp_duration_out,
  output logic clamp_force_high_out,
  output logic clamp_force_low_out,
  output logic clamp_reserved_out
);
  import clamp_regs_pkg::*;

  logic [7:0] clamp_duration_q;
  logic [7:0] oscillator_tally_q;
  logic last_frame_rejected_q;
  logic [DATA_W-1:0] raw_word;
  logic [DATA_W-1:0] parity_word;

  // Only the upper byte is storage; the low byte is never held.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clamp_duration_q <= CLAMP_TIME_RESET[FIELD_MSB:FIELD_LSB];
    end else if (wr_en_in && addr_in == CLAMP_TIME_OFFSET) begin
      clamp_duration_q <= wdata_in[FIELD_MSB:FIELD_LSB];
    end
  end

  AST_WRITE_FIELD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == CLAMP_TIME_OFFSET
    |=> ##1 clamp_duration_out == $past(wdata_in[FIELD_MSB:FIELD_LSB], 2))
    else $error("duration output did not follow write");

  AST_WRITE_OTHER: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_en_in && addr_in == CLAMP_TIME_OFFSET)
    |=> clamp_duration_q == $past(clamp_duration_q))
    else $error("duration field changed without a write to it");

  // The tally has no write path at all, so a host write cannot disturb it.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oscillator_tally_q <= CLOCK_WATCH_RESET[FIELD_MSB:FIELD_LSB];
    end else if (tally_valid_in) begin
      oscillator_tally_q <= tally_in;
    end
  end

  AST_TALLY_RO: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !tally_valid_in
    |=> oscillator_tally_q == $past(oscillator_tally_q))
    else $error("tally changed without clock check");

  AST_TALLY_LOAD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    tally_valid_in
    |=> oscillator_tally_q == $past(tally_in))
    else $error("tally did not take the clock check count");

  // Updated at every frame end; it describes the frame before the current read.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_frame_rejected_q <= 1'b0;
    end else if (frame_done_in) begin
      last_frame_rejected_q <= frame_bad_in;
    end
  end

  AST_REJECT_LOAD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    frame_done_in
    |=> last_frame_rejected_q == $past(frame_bad_in))
    else $error("rejected flag did not take the frame result");

  AST_REJECT_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !frame_done_in
    |=> last_frame_rejected_q == $past(last_frame_rejected_q))
    else $error("rejected flag changed between frames");

  always_comb begin
    raw_word = '0;
    if (addr_in == CLAMP_TIME_OFFSET) begin
      raw_word[FIELD_MSB:FIELD_LSB] = clamp_duration_q;
    end else if (addr_in == CLOCK_WATCH_OFFSET) begin
      raw_word[FIELD_MSB:FIELD_LSB] = oscillator_tally_q;
    end
    raw_word[REJECT_BIT] = last_frame_rejected_q;
  end

  odd_parity_word #(
    .WIDTH(DATA_W)
  ) u_parity (
    .word_in(raw_word),
    .word_out(parity_word)
  );

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= CLAMP_TIME_RESET;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rd_en_in;
      if (rd_en_in) begin
        rdata_out <= parity_word;
      end
    end
  end

  AST_VALID_PULSE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1
    |=> rdata_valid_out == $past(rd_en_in))
    else $error("read valid does not follow the read strobe");

  // The host may sample the word late, so it must stand until the next read.
  AST_READ_HOLD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !rd_en_in
    |=> rdata_out == $past(rdata_out))
    else $error("read word changed without a read");

  AST_REJECT_FLAG: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    frame_done_in ##1 rd_en_in
    |=> rdata_out[REJECT_BIT] == $past(frame_bad_in, 2))
    else $error("rejected flag wrong in read word");

  AST_ODD_PARITY: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rdata_valid_out
    |-> ^rdata_out == 1'b1)
    else $error("read word parity not odd");

  AST_TALLY_READ: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    tally_valid_in ##1 (rd_en_in && !tally_valid_in && addr_in == CLOCK_WATCH_OFFSET)
    |=> rdata_out[FIELD_MSB:FIELD_LSB] == $past(tally_in, 2))
    else $error("tally read back wrong");

  AST_RESERVED_ZERO: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rdata_valid_out
    |-> rdata_out[7:2] == 6'h00)
    else $error("reserved bits not zero");

  AST_UNMAPPED_READ: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in != CLAMP_TIME_OFFSET && addr_in != CLOCK_WATCH_OFFSET
    |=> rdata_out[FIELD_MSB:FIELD_LSB] == 8'h00)
    else $error("unmapped read returned a nonzero field");

  AST_READ_FIELD: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == CLAMP_TIME_OFFSET
    |=> rdata_out[FIELD_MSB:FIELD_LSB] == clamp_duration_out)
    else $error("read field differs from the duration output");

  // Mode outputs follow the stored field one cycle later.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clamp_duration_out <= FIELD_RESET_ZERO;
      clamp_force_high_out <= 1'b0;
      clamp_force_low_out <= 1'b0;
      clamp_reserved_out <= 1'b0;
    end else begin
      clamp_duration_out <= clamp_duration_q;
      clamp_force_high_out <= clamp_duration_q == CLAMP_FORCE_HIGH;
      clamp_force_low_out <= clamp_duration_q == CLAMP_FORCE_LOW;
      clamp_reserved_out <= clamp_duration_q != CLAMP_FORCE_HIGH
        && clamp_duration_q < CLAMP_MIN_VALID;
    end
  end

  AST_FORCE_HIGH: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    clamp_duration_q == CLAMP_FORCE_HIGH
    |=> clamp_force_high_out && !clamp_force_low_out)
    else $error("zero duration did not force high");

  AST_FORCE_LOW: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    clamp_duration_q == CLAMP_FORCE_LOW
    |=> clamp_force_low_out && !clamp_force_high_out)
    else $error("all ones duration did not force low");

  AST_RESERVED_CODE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    clamp_duration_q inside {[8'h01:8'h09]}
    |=> clamp_reserved_out && !clamp_force_high_out && !clamp_force_low_out)
    else $error("reserved duration code not flagged");

  AST_TIMED_CODE: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    clamp_duration_q inside {[8'h0a:8'hfe]}
    |=> !clamp_force_high_out && !clamp_force_low_out && !clamp_reserved_out)
    else $error("valid duration code raised a mode flag");

  // A timed window, a forced level and a reserved code can never be claimed together.
  AST_MODE_ONEHOT: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    1'b1
    |-> $onehot0({clamp_force_high_out, clamp_force_low_out, clamp_reserved_out}))
    else $error("more than one clamp mode flag set");

endmodule // clamp_timing_regs

// [common/clamp_regs_pkg.sv]
// Package for the clamp timing and clock supervision register pair.
// Assumes a register port that carries a 5-bit register address and 16-bit words.
package clamp_regs_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [4:0] CLAMP_TIME_OFFSET = 5'h1e;
  localparam logic [4:0] CLOCK_WATCH_OFFSET = 5'h1f;
  localparam logic [15:0] CLAMP_TIME_RESET = 16'h2600;
  localparam logic [15:0] CLOCK_WATCH_RESET = 16'h0001;
  localparam int unsigned FIELD_MSB = 15;
  localparam int unsigned FIELD_LSB = 8;
  localparam int unsigned REJECT_BIT = 1;
  localparam int unsigned PARITY_BIT = 0;
  localparam logic [7:0] CLAMP_FORCE_HIGH = 8'h00;
  localparam logic [7:0] CLAMP_FORCE_LOW = 8'hff;
  localparam logic [7:0] CLAMP_MIN_VALID = 8'h0a;
  localparam logic [7:0] FIELD_RESET_ZERO = 8'h00;
endpackage

// [design/odd_parity_word.sv]
// Odd parity generator for a returned register word.
// Assumes the parity position is bit 0 and arrives as zero.
`timescale 1ns/1ps
module odd_parity_word #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic [WIDTH-1:0] word_in,
  output logic [WIDTH-1:0] word_out
);
  // Bit 0 is chosen so that the ones count of the whole word is odd.
  always_comb begin
    word_out = word_in;
    word_out[0] = ~(^word_in[WIDTH-1:1]);
  end
endmodule // odd_parity_word

// [verif/host_model.sv]
// Host-side model of serial frame results and clock check tallies.
// Assumes signals change just after a rising edge of the bench clock.
`timescale 1ns/1ps
module host_model (
  input wire logic clk_in,
  output logic done_out = 1'b0,
  output logic bad_out = 1'b0,
  output logic tv_out = 1'b0,
  output logic [7:0] tally_out = 8'h00
);
  task automatic send(input logic f, input logic b, input logic [7:0] t);
    @(posedge clk_in);
    done_out <= f;
    bad_out <= b;
    tv_out <= !f;
    tally_out <= t;
    @(posedge clk_in);
    done_out <= 1'b0;
    tv_out <= 1'b0;
    // Released lines flip so a stale value can never pass for a fresh one.
    bad_out <= ~b;
    tally_out <= ~t;
  endtask
endmodule // host_model

// [verif/tb_clamp_timing_regs.sv]
// Self-checking bench for the clamp timing and clock supervision registers.
// Assumes strobes are taken at rising edges and the read word comes one cycle later.
`timescale 1ns/1ps
module tb_clamp_timing_regs;
  import clamp_regs_pkg::*;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic [4:0] addr_in = 5'h00;
  logic [15:0] wdata_in = 16'h0000, rdata;
  logic fd, fb, tv, rv, fh, fl, rs;
  logic [7:0] tl, dur;
  int error_cnt = 0, compares = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  host_model host (.clk_in(ref_clk_in), .done_out(fd), .bad_out(fb), .tv_out(tv), .tally_out(tl));
  clamp_timing_regs dut (.ref_clk_in, .rst_n_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in,
    .frame_done_in(fd), .frame_bad_in(fb), .tally_valid_in(tv), .tally_in(tl), .rdata_out(rdata),
    .rdata_valid_out(rv), .clamp_duration_out(dur), .clamp_force_high_out(fh),
    .clamp_force_low_out(fl), .clamp_reserved_out(rs));
  function automatic logic [15:0] word(input logic [7:0] f, input logic rej);
    return {f, 6'h00, rej, ~^{f, rej}};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_en_in <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(negedge ref_clk_in);
      if (rv === 1'b1) break;
    end
    chk({15'h0000, rv}, 16'h0001);
    if (rv !== 1'b1) wrap_up();
    chk(rdata, exp);
  endtask
  // The mode outputs settle one cycle after the write strobe is taken.
  task automatic wr(input logic [4:0] a, input logic [15:0] w, input logic [7:0] d);
    @(posedge ref_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wdata_in <= w;
    @(posedge ref_clk_in);
    wr_en_in <= 1'b0;
    wdata_in <= ~w;
    repeat (2) @(negedge ref_clk_in);
    chk({dur, 5'h00, fh, fl, rs},
      {d, 5'h00, d == 8'h00, d == 8'hff, d inside {[8'h01:8'h09]}});
  endtask
  // The read strobe lands on the edge right after the host event, back to back.
  task automatic send_rd(input logic f, input logic b, input logic [7:0] t,
    input logic [4:0] a, input logic [15:0] exp);
    fork
      host.send(f, b, t);
      begin
        @(posedge ref_clk_in);
        rd(a, exp);
      end
    join
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(5'h1e, 16'h2600);
    rd(5'h1f, 16'h0001);
    wr(5'h1e, 16'h00ff, 8'h00);
    rd(5'h1e, word(8'h00, 1'b0));
    wr(5'h1e, 16'hff00, 8'hff);
    rd(5'h1e, 16'hff01);
    wr(5'h1e, 16'h0900, 8'h09);
    wr(5'h1e, 16'hfe00, 8'hfe);
    wr(5'h1e, 16'h0a00, 8'h0a);
    wr(5'h1f, 16'hab00, 8'h0a);
    rd(5'h1f, 16'h0001);
    send_rd(1'b0, 1'b0, 8'h5a, 5'h1f, word(8'h5a, 1'b0));
    rd(5'h10, word(8'h00, 1'b0));
    send_rd(1'b1, 1'b1, 8'h00, 5'h1e, word(8'h0a, 1'b1));
    rd(5'h1f, word(8'h5a, 1'b1));
    send_rd(1'b1, 1'b0, 8'h00, 5'h1e, word(8'h0a, 1'b0));
    // A second reset in mid-run must restore both reset words and the mode outputs.
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk(rdata, CLAMP_TIME_RESET);
    chk({dur, 5'h00, fh, fl, rs}, 16'h0000);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(5'h1f, CLOCK_WATCH_RESET);
    rd(5'h1e, CLAMP_TIME_RESET);
    chk({dur, 5'h00, fh, fl, rs}, {CLAMP_TIME_RESET[15:8], 8'h00});
    wrap_up();
  end
endmodule // tb_clamp_timing_regs
